// [lds_pkg.sv]
package lds_pkg;

	// panel type codes
	localparam logic [1:0] PANEL_TFT       = 2'h0;
	localparam logic [1:0] PANEL_STN_MONO  = 2'h1;
	localparam logic [1:0] PANEL_STN_COLOR = 2'h2;

	// scan layout codes
	localparam logic SCAN_SINGLE = 1'h0;
	localparam logic SCAN_DUAL   = 1'h1;

	// stn bus width codes
	localparam logic [1:0] BUS_WIDTH_4  = 2'h0;
	localparam logic [1:0] BUS_WIDTH_8  = 2'h1;
	localparam logic [1:0] BUS_WIDTH_16 = 2'h2;

	// data bits carried per panel half in one dot
	localparam logic [4:0] HALF_BITS_NARROW = 5'h04;
	localparam logic [4:0] HALF_BITS_WIDE   = 5'h08;
	localparam logic [7:0] HALF_MASK_NARROW = 8'h0F;
	localparam logic [7:0] HALF_MASK_WIDE   = 8'hFF;

	// dithered bits produced per upstream element
	localparam logic [1:0] ELEM_BITS_MONO  = 2'h1;
	localparam logic [1:0] ELEM_BITS_COLOR = 2'h3;

	// clock gating and bias mode codes
	localparam logic GATE_DATA_ONLY = 1'h0;
	localparam logic BIAS_PER_FRAME = 1'h0;

	// pixel fifo shape
	localparam int FIFO_WIDTH = 24;
	localparam int FIFO_DEPTH = 16;

	// shade levels with fixed behaviour, and the level offset of the upper sets
	localparam logic [3:0] LEVEL_OFF     = 4'h0;
	localparam logic [3:0] LEVEL_FULL_ON = 4'hF;
	localparam logic [3:0] LEVEL_UPPER   = 4'h7;

	// pattern sets: index 0 is one half, 1..7 serve levels 8..14
	// groups are packed first group in the top nibble
	localparam int DITHER_SETS = 8;
	localparam logic [27:0] DITHER_PATTERN [DITHER_SETS] = '{
		28'hA500000,
		28'hA5A5A5F,
		28'hA5A5F00,
		28'hDB60000,
		28'hFA5FA5F,
		28'hEDB7000,
		28'hFEDB700,
		28'hFFFEDB7
	};
	localparam logic [2:0] DITHER_LENGTH [DITHER_SETS] = '{
		3'h2, 3'h7, 3'h5, 3'h3, 3'h7, 3'h4, 3'h5, 3'h7
	};
	localparam logic [4:0] TOP_GROUP_SHIFT = 5'h18;

	localparam logic [23:0] DATA_IDLE = 24'h000000;

	typedef enum logic [2:0] {
		ST_IDLE        = 3'h0,
		ST_FRAME_PULSE = 3'h1,
		ST_FRAME_DELAY = 3'h2,
		ST_LINE_PULSE  = 3'h3,
		ST_BACK_PORCH  = 3'h4,
		ST_ACTIVE      = 3'h5,
		ST_FRONT_PORCH = 3'h6
	} lds_state_type;

endpackage

// [lds_fifo.sv]
`timescale 1ns/1ns
module lds_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0]   FULL_COUNT = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wrPtr_reg;
	logic [AW-1:0]    rdPtr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             ready_reg;
	logic             push;
	logic             pop;

	always_comb begin
		push = inValid && ready_reg;
		pop = outValid && outReady;
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	assign inReady = ready_reg;
	assign outValid = count_reg != '0;
	assign outData = store[rdPtr_reg];

	always_ff @(posedge clk) begin
		if (push) begin
			store[wrPtr_reg] <= inData;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
			ready_reg <= 1'b1;
		end else begin
			if (push) begin
				wrPtr_reg <= (wrPtr_reg == LAST) ? '0 : wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_reg <= (rdPtr_reg == LAST) ? '0 : rdPtr_reg + 1'b1;
			end
			count_reg <= count_next;
			ready_reg <= count_next != FULL_COUNT;
		end
	end
endmodule // lds_fifo

// [lds_dither_pattern.sv]
`timescale 1ns/1ns
module lds_dither_pattern (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        frameAdvance,
	output wire logic [31:0] groups
);
	function automatic logic [3:0] pickGroup(input logic [27:0] set,
		input logic [2:0] idx);
		logic [27:0] shifted;
		shifted = set >> (lds_pkg::TOP_GROUP_SHIFT - {idx, 2'h0});
		return shifted[3:0];
	endfunction

	generate
		for (genvar s = 0; s < lds_pkg::DITHER_SETS; s++) begin : gSet
			logic [2:0] index_reg;
			logic [2:0] index_next;
			logic [3:0] group_reg;

			// wraps to the first group after the last one
			always_comb begin
				if (index_reg == lds_pkg::DITHER_LENGTH[s] - 3'h1) begin // [R25]
					index_next = 3'h0;
				end else begin
					index_next = index_reg + 3'h1;
				end
			end

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					index_reg <= 3'h0;
					group_reg <= lds_pkg::DITHER_PATTERN[s][27:24];
				end else if (frameAdvance) begin // [R04]
					index_reg <= index_next;
					group_reg <= pickGroup(lds_pkg::DITHER_PATTERN[s], index_next);
				end
			end

			assign groups[4*s +: 4] = group_reg;
		end
	endgenerate
endmodule // lds_dither_pattern

// [lcd_dither_shift_timing.sv]
`timescale 1ns/1ns
// Contract
// R01: dithering is applied only for STN panel types.
// R02: level 15 always on, level 0 always off, no pattern used.
// R03: levels 8-14 use their sets; 1-7 use inverted complementary sets.
// R04: each set is 4-bit groups, one group further per frame.
// R05: pixel at 4n+m is on when bit 3-m of the group is one.
// R06: colour components take successive positions, bit steps 3,2,1,0, wraps.
// R07: in dual scan each half bus behaves like single scan.
// R08: one pixel or three sub-pixels per step packed into bus words.
// R09: panel type TFT, STN mono or colour; TFT is single scan only.
// R10: STN width 4 (single only), 8, or 16 (dual only) bits.
// R11: dot clock, syncs, valid and bias come from the core clock.
// R12: bias toggles per frame, or after every count+1 line syncs.
// R13: data changes on dot clock falling edge, rising edge selectable.
// R14: dot clock is core clock over divisor+1, bypass runs at core rate (here bypass or divisor 0 toggles the pin each core cycle, period 2).
// R15: dot clock either runs always or only while data is shifted.
// R16: software keeps the dot period at the per-configuration minimum.
// R17: data valid is high only while valid data sits on the bus.
// R18: line sync follows the last data of each line.
// R19: frame-to-line delay+1 dots between frame sync fall and line sync.
// R20: line sync lasts width+1 dots; data starts back porch+1 dots later.
// R21: front porch+frame-to-line delay+2 dots from data end to line sync.
// R22: software makes sync and porch delays cover the datapath latency.
// R23: (delay+width+porch+3) times dot period must reach that latency.
// R24: frame sync once per frame, homing the panel's line pointer.
// R25: per-set frame index wraps so each sequence repeats.
// R26: pattern position restarts each line, counting pixels or sub-pixels.
module lcd_dither_shift_timing (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        displayEnable,
	input  wire logic [1:0]  panelTypeSelect,
	input  wire logic        scanLayoutSelect,
	input  wire logic [1:0]  stnBusWidth,
	input  wire logic [7:0]  dotClockDivisor,
	input  wire logic        dotClockBypass,
	input  wire logic        dotClockGatingSelect,
	input  wire logic        dataOnRisingEdge,
	input  wire logic        biasToggleSelect,
	input  wire logic [7:0]  biasLineCount,
	input  wire logic [7:0]  frameToLineDelay,
	input  wire logic [7:0]  linePulseWidth,
	input  wire logic [7:0]  lineBackPorch,
	input  wire logic [7:0]  lineFrontPorch,
	input  wire logic [9:0]  lineActiveDots,
	input  wire logic [9:0]  frameLineCount,
	input  wire logic        pixelValid,
	output logic             pixelReady,
	input  wire logic [23:0] pixelData,
	output logic             pixelShiftClock,
	output logic             lineSync,
	output logic             frameSync,
	output logic             dataValidOut,
	output logic             acBiasToggle,
	output logic [23:0]      panelDataBus
);
	logic                  isTft;
	logic                  isColor;
	logic                  isDual;
	logic [4:0]            halfBits;
	logic [7:0]            halfMask;
	logic [1:0]            elemBits;
	logic [7:0]            divCount_reg;
	logic [7:0]            divCount_next;
	logic                  toggle_reg;
	logic                  fastMode;
	logic                  dotTick;
	logic [8:0]            highLen;
	logic                  edgeStrobe;
	logic                  clockRaw;
	lds_pkg::lds_state_type state_reg;
	lds_pkg::lds_state_type state_next;
	logic [8:0]            phaseCount_reg;
	logic [8:0]            phaseCount_next;
	logic [9:0]            lineCount_reg;
	logic [9:0]            lineCount_next;
	logic                  frameStart;
	logic                  linePulseDone;
	logic [7:0]            biasCount_reg;
	logic                  activeAtEdge;
	logic                  consume;
	logic                  fifoValid;
	logic [23:0]           fifoData;
	logic                  accept;
	logic                  stage;
	logic                  lineEnd;
	logic                  hold_reg;
	logic [9:0]            wordCount_reg;
	logic [23:0]           staged_reg;
	logic                  stagedValid_reg;
	logic                  curHalf_reg;
	logic                  targetHalf;
	logic [1:0]            halfFull;
	logic [15:0]           halfWord;
	logic [23:0]           busWord;
	logic [31:0]           groups;

	// shade level of one component to on/off for position m
	function automatic logic ditherOn(input logic [3:0] level,
		input logic [31:0] grp, input logic [1:0] m);
		logic [1:0] b;
		logic [2:0] set;
		logic       inv;
		logic       on;
		b = 2'h3 - m; // [R05]
		set = 3'h0;
		inv = 1'b0;
		on = 1'b0;
		case (level) // [R03]
			4'h7: begin
				set = 3'h0;
				inv = 1'b1;
			end
			4'h6: begin
				set = 3'h1;
				inv = 1'b1;
			end
			4'h5: begin
				set = 3'h2;
				inv = 1'b1;
			end
			4'h4: begin
				set = 3'h3;
				inv = 1'b1;
			end
			4'h3: begin
				set = 3'h5;
				inv = 1'b1;
			end
			4'h2: begin
				set = 3'h6;
				inv = 1'b1;
			end
			4'h1: begin
				set = 3'h7;
				inv = 1'b1;
			end
			default: begin
				set = 3'(level - lds_pkg::LEVEL_UPPER);
			end
		endcase
		if (level == lds_pkg::LEVEL_FULL_ON) begin // [R02]
			on = 1'b1;
		end else if (level != lds_pkg::LEVEL_OFF) begin
			on = grp[{set, b}] ^ inv;
		end
		return on;
	endfunction

	// configuration decode
	always_comb begin
		isTft = panelTypeSelect == lds_pkg::PANEL_TFT; // [R09]
		isColor = panelTypeSelect == lds_pkg::PANEL_STN_COLOR;
		isDual = !isTft && scanLayoutSelect == lds_pkg::SCAN_DUAL; // [R09]
		if (isDual) begin // [R10]
			halfBits = (stnBusWidth == lds_pkg::BUS_WIDTH_16) ?
				lds_pkg::HALF_BITS_WIDE : lds_pkg::HALF_BITS_NARROW;
		end else begin
			halfBits = (stnBusWidth == lds_pkg::BUS_WIDTH_4) ?
				lds_pkg::HALF_BITS_NARROW : lds_pkg::HALF_BITS_WIDE;
		end
		halfMask = (halfBits == lds_pkg::HALF_BITS_NARROW) ?
			lds_pkg::HALF_MASK_NARROW : lds_pkg::HALF_MASK_WIDE;
		elemBits = isColor ? lds_pkg::ELEM_BITS_COLOR : lds_pkg::ELEM_BITS_MONO;
	end

	// dot clock divider and data edge selection
	always_comb begin
		fastMode = dotClockBypass || dotClockDivisor == 8'h00;
		dotTick = fastMode || divCount_reg == dotClockDivisor; // [R14]
		divCount_next = dotTick ? 8'h00 : divCount_reg + 8'h01;
		highLen = 9'(({1'b0, dotClockDivisor} + 9'h002) >> 1);
		clockRaw = fastMode ? ~toggle_reg : ({1'b0, divCount_next} < highLen);
		if (fastMode) begin // [R13]
			edgeStrobe = 1'b1;
		end else if (dataOnRisingEdge) begin
			edgeStrobe = divCount_next == 8'h00;
		end else begin
			edgeStrobe = {1'b0, divCount_next} == highLen;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			divCount_reg <= 8'h00;
			toggle_reg <= 1'b0;
		end else begin
			divCount_reg <= divCount_next; // [R11]
			toggle_reg <= ~toggle_reg;
		end
	end

	// line and frame sequencing, one step per dot
	always_comb begin
		state_next = state_reg;
		phaseCount_next = phaseCount_reg;
		lineCount_next = lineCount_reg;
		frameStart = 1'b0;
		linePulseDone = 1'b0;
		if (dotTick) begin
			if (!displayEnable) begin
				state_next = lds_pkg::ST_IDLE;
			end else if (state_reg != lds_pkg::ST_IDLE &&
				phaseCount_reg != 9'h000) begin
				phaseCount_next = phaseCount_reg - 9'h001;
			end else begin
				case (state_reg)
					lds_pkg::ST_FRAME_PULSE: begin
						state_next = lds_pkg::ST_FRAME_DELAY;
						phaseCount_next = {1'b0, frameToLineDelay}; // [R19]
					end
					lds_pkg::ST_FRAME_DELAY: begin
						state_next = lds_pkg::ST_LINE_PULSE;
						phaseCount_next = {1'b0, linePulseWidth}; // [R20]
					end
					lds_pkg::ST_LINE_PULSE: begin
						state_next = lds_pkg::ST_BACK_PORCH;
						phaseCount_next = {1'b0, lineBackPorch}; // [R20]
						linePulseDone = 1'b1;
					end
					lds_pkg::ST_BACK_PORCH: begin
						state_next = lds_pkg::ST_ACTIVE;
						phaseCount_next = lineActiveDots[8:0];
					end
					lds_pkg::ST_ACTIVE: begin
						state_next = lds_pkg::ST_FRONT_PORCH; // [R18]
						phaseCount_next = {1'b0, lineFrontPorch} +
							{1'b0, frameToLineDelay} + 9'h001; // [R21]
					end
					lds_pkg::ST_FRONT_PORCH: begin
						phaseCount_next = {1'b0, linePulseWidth};
						if (lineCount_reg == frameLineCount) begin
							state_next = lds_pkg::ST_FRAME_PULSE; // [R24]
							lineCount_next = 10'h000;
							frameStart = 1'b1;
						end else begin
							state_next = lds_pkg::ST_LINE_PULSE;
							lineCount_next = lineCount_reg + 10'h001;
						end
					end
					default: begin
						state_next = lds_pkg::ST_FRAME_PULSE; // [R24]
						phaseCount_next = {1'b0, linePulseWidth};
						lineCount_next = 10'h000;
						frameStart = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= lds_pkg::ST_IDLE;
			phaseCount_reg <= 9'h000;
			lineCount_reg <= 10'h000;
		end else begin
			state_reg <= state_next;
			phaseCount_reg <= phaseCount_next;
			lineCount_reg <= lineCount_next;
		end
	end
	// ac bias
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			acBiasToggle <= 1'b0;
			biasCount_reg <= 8'h00;
		end else if (biasToggleSelect == lds_pkg::BIAS_PER_FRAME) begin
			biasCount_reg <= 8'h00;
			if (frameStart) begin // [R12]
				acBiasToggle <= ~acBiasToggle;
			end
		end else if (linePulseDone) begin
			if (biasCount_reg == biasLineCount) begin // [R12]
				biasCount_reg <= 8'h00;
				acBiasToggle <= ~acBiasToggle;
			end else begin
				biasCount_reg <= biasCount_reg + 8'h01;
			end
		end
	end

	// panel pins
	always_comb begin
		// a falling-edge strobe loads the word of the coming dot
		activeAtEdge = (fastMode || dataOnRisingEdge) ? // [R20]
			state_next == lds_pkg::ST_ACTIVE : displayEnable &&
			(state_reg == lds_pkg::ST_ACTIVE ? phaseCount_reg != 9'h000 :
			state_reg == lds_pkg::ST_BACK_PORCH && phaseCount_reg == 9'h000);
		consume = edgeStrobe && activeAtEdge && stagedValid_reg;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pixelShiftClock <= 1'b0;
			lineSync <= 1'b0;
			frameSync <= 1'b0;
			dataValidOut <= 1'b0;
			panelDataBus <= lds_pkg::DATA_IDLE;
		end else begin
			if (dotClockGatingSelect == lds_pkg::GATE_DATA_ONLY) begin // [R15]
				pixelShiftClock <= clockRaw &&
					state_next == lds_pkg::ST_ACTIVE;
			end else begin
				pixelShiftClock <= clockRaw;
			end
			lineSync <= state_next == lds_pkg::ST_LINE_PULSE; // [R18]
			frameSync <= state_next == lds_pkg::ST_FRAME_PULSE; // [R24]
			if (consume) begin
				dataValidOut <= 1'b1; // [R17]
				panelDataBus <= staged_reg;
			end else if (edgeStrobe) begin
				dataValidOut <= 1'b0; // [R17]
				panelDataBus <= lds_pkg::DATA_IDLE;
			end
		end
	end

	// packing of dithered elements into bus words
	always_comb begin
		targetHalf = isDual ? curHalf_reg : 1'b0;
		stage = !stagedValid_reg && (isTft ? (fifoValid && !hold_reg) :
			(halfFull[0] && (!isDual || halfFull[1])));
		accept = !hold_reg && fifoValid && (isTft ? !stagedValid_reg :
			!halfFull[targetHalf]);
		lineEnd = stage && wordCount_reg == lineActiveDots;
		if (!isDual) begin // [R08]
			busWord = {16'h0000, halfWord[7:0]};
		end else if (halfBits == lds_pkg::HALF_BITS_NARROW) begin // [R07]
			busWord = {16'h0000, halfWord[11:8], halfWord[3:0]};
		end else begin
			busWord = {8'h00, halfWord[15:8], halfWord[7:0]};
		end
	end

	generate
		for (genvar h = 0; h < 2; h++) begin : gHalf
			logic [15:0] acc_reg;
			logic [4:0]  accCnt_reg;
			logic [1:0]  pos_reg;
			logic [2:0]  ditherBits;
			logic [15:0] shifted;

			always_comb begin
				halfFull[h] = accCnt_reg >= halfBits;
				shifted = acc_reg >> (accCnt_reg - halfBits);
				halfWord[8*h +: 8] = shifted[7:0] & halfMask;
				if (isColor) begin // [R06]
					ditherBits = {ditherOn(fifoData[11:8], groups, pos_reg),
						ditherOn(fifoData[7:4], groups, pos_reg + 2'h1),
						ditherOn(fifoData[3:0], groups, pos_reg + 2'h2)};
				end else begin
					ditherBits = {2'h0, ditherOn(fifoData[3:0], groups, pos_reg)};
				end
			end

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					acc_reg <= 16'h0000;
					accCnt_reg <= 5'h00;
					pos_reg <= 2'h0;
				end else if (lineEnd || isTft) begin // [R01]
					accCnt_reg <= 5'h00;
					pos_reg <= 2'h0; // [R26]
				end else if (accept && targetHalf == 1'(h)) begin
					acc_reg <= (acc_reg << elemBits) | {13'h0000, ditherBits};
					accCnt_reg <= accCnt_reg + {3'h0, elemBits};
					pos_reg <= pos_reg + elemBits; // [R26]
				end else if (stage) begin
					accCnt_reg <= accCnt_reg - halfBits;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hold_reg <= 1'b1;
			wordCount_reg <= 10'h000;
			curHalf_reg <= 1'b0;
		end else begin
			if (lineEnd) begin
				hold_reg <= 1'b1;
			end else if (state_reg == lds_pkg::ST_LINE_PULSE) begin
				hold_reg <= 1'b0;
			end
			if (lineEnd) begin
				wordCount_reg <= 10'h000;
			end else if (stage) begin
				wordCount_reg <= wordCount_reg + 10'h001;
			end
			if (lineEnd || !isDual) begin
				curHalf_reg <= 1'b0;
			end else if (accept) begin
				curHalf_reg <= ~curHalf_reg; // [R07]
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			staged_reg <= lds_pkg::DATA_IDLE;
			stagedValid_reg <= 1'b0;
		end else if (stage) begin
			staged_reg <= isTft ? fifoData : busWord; // [R08]
			stagedValid_reg <= 1'b1;
		end else if (consume) begin
			stagedValid_reg <= 1'b0;
		end
	end

	lds_fifo #(
		.WIDTH (lds_pkg::FIFO_WIDTH),
		.DEPTH (lds_pkg::FIFO_DEPTH)
	) pixelFifo (
		.clk      (clk),
		.reset    (reset),
		.inValid  (pixelValid),
		.inReady  (pixelReady),
		.inData   (pixelData),
		.outValid (fifoValid),
		.outReady (accept),
		.outData  (fifoData)
	);

	lds_dither_pattern patterns (
		.clk          (clk),
		.reset        (reset),
		.frameAdvance (frameStart),
		.groups       (groups)
	);
endmodule // lcd_dither_shift_timing

// [lds_sva.sv]
`timescale 1ns/1ns
module lds_sva (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [1:0]  panelTypeSelect,
	input wire logic        scanLayoutSelect,
	input wire logic [1:0]  stnBusWidth,
	input wire logic [7:0]  dotClockDivisor,
	input wire logic        dotClockBypass,
	input wire logic        dotClockGatingSelect,
	input wire logic        biasToggleSelect,
	input wire logic [7:0]  linePulseWidth,
	input wire logic        pixelShiftClock,
	input wire logic        lineSync,
	input wire logic        frameSync,
	input wire logic        dataValidOut,
	input wire logic        acBiasToggle,
	input wire logic [23:0] panelDataBus
);
	logic [16:0] per, wid, lineCnt, frameCnt;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	assign per = (dotClockBypass || dotClockDivisor == 8'h00) ? 17'h00001
		: {9'h000, dotClockDivisor} + 17'h00001;
	assign wid = ({9'h000, linePulseWidth} + 17'h00001) * per;
	// high-phase length of each sync in core cycles
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lineCnt <= 17'h00000;
			frameCnt <= 17'h00000;
		end else begin
			lineCnt <= lineSync ? lineCnt + 17'h00001 : 17'h00000;
			frameCnt <= frameSync ? frameCnt + 17'h00001 : 17'h00000;
		end
	end
	sequence s_line_end;
		$fell(lineSync);
	endsequence
	sequence s_frame_end;
		$fell(frameSync);
	endsequence
	property p_idle_bus;
		!dataValidOut |-> panelDataBus == lds_pkg::DATA_IDLE;
	endproperty
	a_idle_bus: assert property (p_idle_bus)
		else $error("bus not idle without valid");
	property p_valid_no_sync;
		dataValidOut |-> !lineSync && !frameSync;
	endproperty
	a_valid_no_sync: assert property (p_valid_no_sync)
		else $error("valid data during sync");
	property p_narrow;
		panelTypeSelect != lds_pkg::PANEL_TFT
		&& scanLayoutSelect == lds_pkg::SCAN_SINGLE
		&& stnBusWidth == lds_pkg::BUS_WIDTH_4
		|-> panelDataBus[23:4] == 20'h00000;
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("unused bus bits driven");
	property p_dual_half;
		panelTypeSelect != lds_pkg::PANEL_TFT
		&& scanLayoutSelect == lds_pkg::SCAN_DUAL
		&& stnBusWidth != lds_pkg::BUS_WIDTH_16
		|-> panelDataBus[23:8] == 16'h0000;
	endproperty
	a_dual_half: assert property (p_dual_half)
		else $error("dual halves outside low byte");
	property p_line_width;
		s_line_end |-> lineCnt == wid;
	endproperty
	a_line_width: assert property (p_line_width)
		else $error("line sync width wrong");
	property p_frame_width;
		s_frame_end |-> frameCnt == wid;
	endproperty
	a_frame_width: assert property (p_frame_width)
		else $error("frame sync width wrong");
	property p_gated_clk;
		dotClockGatingSelect == lds_pkg::GATE_DATA_ONLY
		&& (lineSync || frameSync) |-> !pixelShiftClock;
	endproperty
	a_gated_clk: assert property (p_gated_clk)
		else $error("gated dot clock runs in sync");
	property p_bias_frame;
		biasToggleSelect == lds_pkg::BIAS_PER_FRAME && $changed(acBiasToggle)
		|-> ##[0:1] frameSync;
	endproperty
	a_bias_frame: assert property (p_bias_frame)
		else $error("bias toggled away from frame start");
endmodule // lds_sva

bind lcd_dither_shift_timing lds_sva u_sva (.clk, .reset, .panelTypeSelect,
	.scanLayoutSelect, .stnBusWidth, .dotClockDivisor, .dotClockBypass,
	.dotClockGatingSelect, .biasToggleSelect, .linePulseWidth,
	.pixelShiftClock, .lineSync, .frameSync, .dataValidOut, .acBiasToggle,
	.panelDataBus);

// [lds_panel_model.sv]
`timescale 1ns/1ns
// column driver: latches the first four words of each line, counts dots and lines
module lds_panel_model (
	input  wire logic        pixelShiftClock,
	input  wire logic        dataOnRisingEdge,
	input  wire logic        lineSync,
	input  wire logic        dataValidOut,
	input  wire logic [23:0] panelDataBus,
	output logic [23:0]      dotWord [4],
	output int               lineDots,
	output int               lines
);
	int dotIdx = 0;
	initial lines = 0;
	// sample on the edge opposite the data change
	always @(pixelShiftClock) begin
		if ((pixelShiftClock ^ dataOnRisingEdge) && dataValidOut) begin
			if (dotIdx < 4)
				dotWord[dotIdx] <= panelDataBus;
			dotIdx <= dotIdx + 1;
		end
	end
	always @(posedge lineSync) begin
		lineDots <= dotIdx;
		dotIdx <= 0;
		lines <= lines + 1;
	end
endmodule // lds_panel_model

// [lcd_dither_shift_timing_tb.sv]
`timescale 1ns/1ns
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %h seen %h", n, e, a); end end
module lcd_dither_shift_timing_tb;
	logic        clk = 1'b0, reset = 1'b1, displayEnable = 1'b1;
	logic        scanLayoutSelect = 1'b0, pixelValid = 1'b0;
	logic        dotClockBypass = 1'b0, dotClockGatingSelect = 1'b0;
	logic        dataOnRisingEdge = 1'b0, biasToggleSelect = 1'b0;
	logic        pixelReady, pixelShiftClock, lineSync, frameSync;
	logic        dataValidOut, acBiasToggle;
	logic [1:0]  panelTypeSelect = 2'h1, stnBusWidth = 2'h0;
	logic [7:0]  dotClockDivisor = 8'h07, biasLineCount = 8'h00;
	logic [7:0]  frameToLineDelay = 8'h02, linePulseWidth = 8'h01;
	logic [7:0]  lineBackPorch = 8'h07, lineFrontPorch = 8'h00;
	logic [9:0]  lineActiveDots = 10'h003, frameLineCount = 10'h001;
	logic [23:0] pixelData = 24'h00000F, panelDataBus;
	logic [23:0] dotWord [4];
	int          lineDots, lines, n_fail = 0, cmp_count = 0;
	always #20 clk = ~clk;
	lcd_dither_shift_timing uut (.clk, .reset, .displayEnable,
		.panelTypeSelect, .scanLayoutSelect, .stnBusWidth, .dotClockDivisor,
		.dotClockBypass, .dotClockGatingSelect, .dataOnRisingEdge,
		.biasToggleSelect, .biasLineCount, .frameToLineDelay, .linePulseWidth,
		.lineBackPorch, .lineFrontPorch, .lineActiveDots, .frameLineCount,
		.pixelValid, .pixelReady, .pixelData, .pixelShiftClock, .lineSync,
		.frameSync, .dataValidOut, .acBiasToggle, .panelDataBus);
	lds_panel_model panel (.pixelShiftClock, .dataOnRisingEdge, .lineSync,
		.dataValidOut, .panelDataBus, .dotWord, .lineDots, .lines);
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return lineSync;
			1: return frameSync;
			2: return acBiasToggle;
			default: return pixelShiftClock;
		endcase
	endfunction
	task automatic waitFor(input int s, input logic v, output int c);
		for (c = 0; c < 20000 && pick(s) !== v; c++)
			@(negedge clk);
		if (c == 20000) begin
			n_fail++;
			$display("timeout on signal %0d", s);
			summarize();
		end
	endtask
	task automatic waitPulses(input int s, input int n);
		int c;
		repeat (n) begin
			waitFor(s, 1'b0, c);
			waitFor(s, 1'b1, c);
		end
	endtask
	task automatic dotPeriod(output int p);
		int a;
		waitFor(3, 1'b0, a);
		waitFor(3, 1'b1, a);
		waitFor(3, 1'b0, a);
		waitFor(3, 1'b1, p);
		p = p + a;
	endtask
	// config may only change while reset is held
	task automatic hold();
		@(negedge clk);
		reset = 1'b1;
		pixelValid = 1'b0;
	endtask
	task automatic go();
		repeat (2) @(negedge clk);
		reset = 1'b0;
		pixelValid = 1'b1;
	endtask
	task automatic tMono();
		int k;
		waitPulses(0, 3);
		for (k = 0; k < 4; k++)
			`CHK("full dot", 24'h00000F, dotWord[k])
		`CHK("dots per line", 4, lineDots)
		`CHK("fifo full", 1'b0, pixelReady)
		hold();
		pixelData = 24'h000000;
		go();
		waitPulses(0, 3);
		`CHK("off dot", 24'h000000, dotWord[2])
		`CHK("off dots per line", 4, lineDots)
		$display("mono done");
	endtask
	task automatic tColor();
		hold();
		panelTypeSelect = lds_pkg::PANEL_STN_COLOR;
		pixelData = 24'h000F00;
		go();
		waitPulses(0, 3);
		`CHK("color dot0", 24'h000009, dotWord[0])
		`CHK("color dot1", 24'h000002, dotWord[1])
		`CHK("color dot2", 24'h000004, dotWord[2])
		`CHK("color dot3", 24'h000009, dotWord[3])
		$display("color done");
	endtask
	function automatic logic [23:0] grp(logic [27:0] s, int i, logic d);
		logic [3:0] g;
		g = s[27 - 4 * i -: 4];
		return d ? {16'h0000, g, g} : {20'h00000, g};
	endfunction
	task automatic tDither(logic [27:0] sq, int len, logic d, logic [3:0] lv);
		logic [23:0] w [8];
		int c, p, k, hit;
		hold();
		panelTypeSelect = lds_pkg::PANEL_STN_MONO;
		scanLayoutSelect = d;
		stnBusWidth = d ? lds_pkg::BUS_WIDTH_8 : lds_pkg::BUS_WIDTH_4;
		dotClockDivisor = d ? 8'h0F : 8'h07;
		pixelData = {20'h00000, lv};
		go();
		waitPulses(1, 2);
		for (k = 0; k < 8; k++) begin
			waitPulses(1, 1);
			w[k] = dotWord[0];
		end
		hit = 0;
		for (p = 0; p < len; p++) begin
			c = 1;
			for (k = 0; k < 8; k++)
				if (w[k] !== grp(sq, (p + k) % len, d))
					c = 0;
			hit = hit | c;
		end
		`CHK("dither sequence", 1, hit)
		$display("dither level %0d done", lv);
	endtask
	task automatic tTft();
		int p;
		hold();
		panelTypeSelect = lds_pkg::PANEL_TFT;
		dotClockDivisor = 8'h03;
		dotClockGatingSelect = 1'b1;
		dataOnRisingEdge = 1'b1;
		pixelData = 24'h5A3C69;
		go();
		waitPulses(0, 3);
		`CHK("tft word", 24'h5A3C69, dotWord[1])
		dotPeriod(p);
		`CHK("dot period", 4, p)
		hold();
		dotClockBypass = 1'b1;
		go();
		waitPulses(0, 2);
		dotPeriod(p);
		`CHK("bypass pin period", 2, p)
		$display("tft done");
	endtask
	task automatic tBias(logic sel, logic [7:0] cnt, int exp);
		int c, l;
		hold();
		panelTypeSelect = lds_pkg::PANEL_STN_MONO;
		dotClockDivisor = 8'h07;
		dotClockBypass = 1'b0;
		dotClockGatingSelect = 1'b0;
		dataOnRisingEdge = 1'b0;
		biasToggleSelect = sel;
		biasLineCount = cnt;
		frameToLineDelay = 8'h03;
		linePulseWidth = 8'h02;
		lineFrontPorch = 8'h01;
		go();
		waitPulses(1, 1);
		waitFor(1, 1'b0, c);
		waitFor(0, 1'b1, c);
		`CHK("frame to line gap", 32, c)
		waitFor(2, !acBiasToggle, c);
		l = lines;
		waitFor(2, !acBiasToggle, c);
		`CHK("lines per bias toggle", exp, lines - l)
		$display("bias done");
	endtask
	initial begin
		go();
		tMono();
		tColor();
		tDither(28'hA5A5F00, 5, 1'b0, 4'h9);
		tDither(28'h0001248, 7, 1'b0, 4'h1);
		tDither(28'h5A00000, 2, 1'b1, 4'h7);
		tTft();
		tBias(1'b0, 8'h00, 2);
		tBias(1'b1, 8'h00, 1);
		tBias(1'b1, 8'h02, 3);
		summarize();
	end
endmodule // lcd_dither_shift_timing_tb
